// File: dv/dual_timer_counter_tb_top.sv
// self-checking bench for the dual timer/event counter
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_tb_top;
    localparam logic [7:0] v0 = tec_pkg::CNT0_VAL_ADDR;
    localparam logic [7:0] c0 = tec_pkg::CNT0_CTL_ADDR;
    localparam logic [7:0] v1 = tec_pkg::CNT1_VAL_ADDR;
    localparam logic [7:0] c1 = tec_pkg::CNT1_CTL_ADDR;
    localparam logic [7:0] ib = tec_pkg::IRQB_ADDR;
    localparam logic [7:0] ia = tec_pkg::IRQA_ADDR;
    logic clk;
    logic rstn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rdata;
    logic cnt0_irq;
    logic cnt1_irq;
    logic wakeup;
    wire pin0;
    wire pin1;
    int bad_count;
    int compares;

    dual_timer_counter i_dual_timer_counter (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
        .RDATA(rdata), .CNT0_INPUT_PIN(pin0), .CNT1_INPUT_PIN(pin1),
        .CNT0_IRQ(cnt0_irq), .CNT1_IRQ(cnt1_irq), .WAKEUP(wakeup)
    );
    ext_pulse_source i_ext_pulse_source (.CLK(clk), .PIN0(pin0), .PIN1(pin1));

    // ----------------------------------------
    // bus and check helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, m);
    endtask
    // bounded: a lost overflow must not hang the run
    task automatic wake(output int n);
        for (n = 1; n < 2000; n++) begin
            @(posedge clk);
            #1;
            if (wakeup === 1'b1) return;
        end
        bad_count++;
        $display("MISMATCH t=%0t wake-up timeout", $time);
        end_of_test();
    endtask
    task automatic pin(input int n, input logic v);
        i_ext_pulse_source.set_pin(n, v);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rchk(c0, tec_pkg::CTL_RESET, "ctl0 reset");
        rchk(c1, tec_pkg::CTL_RESET, "ctl1 reset");
        rchk(8'h55, 8'h00, "unmapped read");
        wr(8'h55, 8'hFF);
        wr(c0, 8'h2F);
        wr(c1, 8'h2F);
        rchk(c0, 8'h0F, "ctl0 unused bits");
        rchk(c1, 8'h08, "ctl1 unused bits");
        $display("test regs done");
    endtask
    task automatic t_prescale();
        int n;
        wr(ia, 8'h04);
        for (int s = 0; s < 8; s++) begin
            wr(c0, 8'h00);
            wr(v0, 8'hFF);
            wr(c0, 8'h90 | s[7:0]);
            repeat (3) wake(n);
            chk(n[7:0], 8'h01 << (s < 2 ? 1 : s), "cnt0 tick gap");
        end
        wr(c0, 8'h00);
        chk({7'h00, cnt0_irq}, 8'h01, "irq0 on");
        rchk(ia, 8'h44, "flag0 set");
        wr(ia, 8'h00);
        wr(v1, 8'hFF);
        wr(c1, 8'h90);
        repeat (3) wake(n);
        chk(n[7:0], 8'h04, "cnt1 tick gap");
        wr(c1, 8'h00);
        $display("test prescale done");
    endtask
    task automatic t_irq();
        int n;
        wr(ib, 8'h02);
        wr(v1, 8'hFE);
        rchk(v1, 8'hFE, "stopped load");
        wr(c1, 8'h90);
        wake(n);
        rchk(v1, 8'hFE, "reload");
        rchk(ib, 8'h22, "flag set");
        chk({7'h00, cnt1_irq}, 8'h01, "irq on");
        wr(ib, 8'h00);
        wake(n);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, cnt1_irq}, 8'h00, "irq masked");
        rchk(ib, 8'h20, "flag kept");
        wr(c1, 8'h00);
        wr(v1, 8'h80);
        // event mode with a quiet pin: count stands while the preload moves
        wr(c1, 8'h50);
        wr(v1, 8'h40);
        rchk(v1, 8'h80, "count unchanged");
        wr(c1, 8'h90);
        wake(n);
        rchk(v1, 8'h40, "new preload");
        wr(c1, 8'h00);
        // the stop lands on a tick, so reload a known count
        wr(v1, 8'h40);
        wr(ib, 8'h00);
        wr(c1, 8'h10);
        repeat (4) pin(1, 1'b1);
        repeat (40) pin(1, 1'b0);
        rchk(v1, 8'h40, "mode off count");
        rchk(ib, 8'h00, "mode off flag");
        wr(c1, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_event();
        logic [7:0] va;
        logic [7:0] ca;
        for (int k = 0; k < 4; k++) begin
            va = k[1] ? v1 : v0;
            ca = k[1] ? c1 : c0;
            wr(ca, 8'h00);
            wr(va, 8'h00);
            wr(ca, {4'h5, k[0], 3'h0});
            pin(k / 2, 1'b1);
            repeat (6) @(posedge clk);
            rchk(va, {7'h00, ~k[0]}, "after rise");
            pin(k / 2, 1'b0);
            repeat (6) @(posedge clk);
            rchk(va, 8'h01, "after fall");
            wr(ca, 8'h00);
        end
        $display("test event done");
    endtask
    task automatic t_pulse();
        logic [7:0] d;
        logic e;
        for (int k = 0; k < 2; k++) begin
            e = k[0];
            wr(v0, 8'h00);
            pin(0, ~e);
            repeat (6) @(posedge clk);
            wr(c0, {4'hD, e, 3'h0});
            repeat (4) @(posedge clk);
            pin(0, e);
            repeat (20) @(posedge clk);
            pin(0, ~e);
            repeat (10) @(posedge clk);
            rd(v0, d);
            chk({7'h00, d >= 8'h08 && d <= 8'h0C}, 8'h01, "width");
            rchk(c0, {4'hC, e, 3'h0}, "run cleared");
            pin(0, e);
            repeat (20) @(posedge clk);
            pin(0, ~e);
            repeat (10) @(posedge clk);
            rchk(v0, d, "result held");
            wr(c0, 8'h00);
        end
        $display("test pulse done");
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_prescale();
        t_irq();
        t_event();
        t_pulse();
        end_of_test();
    end
endmodule
`default_nettype wire

// File: dv/ext_pulse_source.sv
// far-side model: drives the two external counter pins
`timescale 1ns/1ns
`default_nettype none
module ext_pulse_source (
    input wire logic CLK,
    output logic PIN0,
    output logic PIN1
);
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    initial begin
        PIN0 = 1'b0;
        PIN1 = 1'b0;
    end
    // changed just after an edge so runs repeat exactly
    task automatic set_pin(input int n, input logic v);
        @(posedge CLK);
        if (n == 0) begin
            PIN0 <= v;
        end else begin
            PIN1 <= v;
        end
    endtask
endmodule
`default_nettype wire

// File: shared/tec_pkg.sv
// constants for the dual 8-bit timer/event counter block
package tec_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] CNT0_VAL_ADDR = 8'h0D;
    localparam logic [7:0] CNT0_CTL_ADDR = 8'h0E;
    localparam logic [7:0] CNT1_VAL_ADDR = 8'h10;
    localparam logic [7:0] CNT1_CTL_ADDR = 8'h11;
    localparam logic [7:0] IRQA_ADDR = 8'h0B;
    localparam logic [7:0] IRQB_ADDR = 8'h1E;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int RUN_BIT = 4;
    localparam int EDGE_BIT = 3;
    localparam int PSC_HI = 2;
    localparam int CNT0_FLAG_BIT = 6;
    localparam int CNT0_EN_BIT = 2;
    localparam int CNT1_FLAG_BIT = 5;
    localparam int CNT1_EN_BIT = 1;

    // ----------------------------------------
    // reset values and masks
    // ----------------------------------------
    localparam logic [7:0] CTL_RESET = 8'h08;
    localparam logic [7:0] CTL0_MASK = 8'hDF;
    localparam logic [7:0] CTL1_MASK = 8'hD8;
    localparam logic [7:0] IRQA_MASK = 8'h44;
    localparam logic [7:0] IRQB_MASK = 8'h22;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [6:0] DIV4_MASK = 7'h03;
    localparam logic [2:0] PSC_MIN = 3'h1;

    // ----------------------------------------
    // modes and pulse-width states
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PULSE = 2'h3
    } mode_e;

    typedef enum logic [2:0] {
        PW_IDLE = 3'h1,
        PW_ARMED = 3'h2,
        PW_MEAS = 3'h4
    } pw_e;
endpackage

// File: src/dual_timer_counter.sv
// two 8-bit count-up timer/event counters with preload and control
`timescale 1ns/1ns
`default_nettype none

// Function
// - counter 0 clocks from pin or prescaler
// - counter 1 internal clock is clock/4
// - write goes to preload, read returns count
// - mode bits 7:6 select event/timer/pulse
// - overflow reloads preload and sets flag
// - pulse mode: start on edge, stop, clear run
// - measurement kept until run set again
// - pulse mode edge-started; overflow reloads, flags
// - run bit 4 enables; software stops it
// - any overflow is a wake-up source
// - cleared enable blocks overflow interrupt
// - stopped counter loads written value directly
// - running counter takes new preload at overflow
// - reading a counter blocks its count clock
// - counter 0 prescaler: /2 to /128
// - event mode edge: 0 rising, 1 falling
// - pulse mode edge: 0 low pulse, 1 high
// - pulse measurement counts internal clock
module dual_timer_counter (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic CNT0_INPUT_PIN,
    input wire logic CNT1_INPUT_PIN,
    output logic CNT0_IRQ,
    output logic CNT1_IRQ,
    output logic WAKEUP
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic div_tick(input logic [6:0] psc, input logic [6:0] m);
        return (psc & m) == m;
    endfunction

    function automatic logic [6:0] psc_mask(input logic [2:0] sel);
        logic [2:0] n;
        n = (sel < tec_pkg::PSC_MIN) ? tec_pkg::PSC_MIN : sel;
        return 7'((8'h01 << n) - 8'h01);
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] pin_m_q;
    logic [1:0] pin_s_q;
    logic [1:0] pin_p_q;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_m_q <= 2'h0;
            pin_s_q <= 2'h0;
            pin_p_q <= 2'h0;
        end else begin
            pin_m_q <= {CNT1_INPUT_PIN, CNT0_INPUT_PIN};
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
        end
    end

    // ----------------------------------------
    // shared prescaler
    // ----------------------------------------
    // one free-running chain feeds both counters, so ticks of the two stay aligned
    logic [6:0] psc_q;
    logic [6:0] psc_d;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic tick0;
    logic tick1;

    assign psc_d = psc_q + 7'h01;
    assign tick0 = div_tick(psc_q, psc_mask(ctl0[tec_pkg::PSC_HI:0]));
    assign tick1 = div_tick(psc_q, tec_pkg::DIV4_MASK);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            psc_q <= 7'h00;
        end else begin
            psc_q <= psc_d;
        end
    end

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic [1:0] wr_val;
    logic [1:0] wr_ctl;
    logic [1:0] rd_val;
    logic wr_irqa;
    logic wr_irqb;

    assign wr_val = {WR & (ADDR == tec_pkg::CNT1_VAL_ADDR), WR & (ADDR == tec_pkg::CNT0_VAL_ADDR)};
    assign wr_ctl = {WR & (ADDR == tec_pkg::CNT1_CTL_ADDR), WR & (ADDR == tec_pkg::CNT0_CTL_ADDR)};
    assign rd_val = {RD & (ADDR == tec_pkg::CNT1_VAL_ADDR), RD & (ADDR == tec_pkg::CNT0_VAL_ADDR)};
    assign wr_irqa = WR & (ADDR == tec_pkg::IRQA_ADDR);
    assign wr_irqb = WR & (ADDR == tec_pkg::IRQB_ADDR);

    // ----------------------------------------
    // counters
    // ----------------------------------------
    logic [7:0] cnt_q [2];
    logic [7:0] pre_q [2];
    logic [7:0] ctl_q [2];
    tec_pkg::pw_e pw_q [2];
    logic [1:0] adv;
    logic [1:0] ovf;
    logic [1:0] pw_done;

    assign ctl0 = ctl_q[0];
    assign ctl1 = ctl_q[1];

    for (genvar i = 0; i < 2; i++) begin : g_cnt
        tec_pkg::mode_e mode;
        logic run;
        logic esel;
        logic rise;
        logic fall;
        logic ev_edge;
        logic start_e;
        logic stop_e;
        logic int_tick;
        logic pulse_on;
        logic [7:0] mask;
        tec_pkg::pw_e pw_d;

        assign mode = tec_pkg::mode_e'(ctl_q[i][tec_pkg::MODE_HI:tec_pkg::MODE_LO]);
        assign run = ctl_q[i][tec_pkg::RUN_BIT];
        assign esel = ctl_q[i][tec_pkg::EDGE_BIT];
        assign rise = pin_s_q[i] & ~pin_p_q[i];
        assign fall = ~pin_s_q[i] & pin_p_q[i];
        assign ev_edge = esel ? fall : rise;
        assign start_e = esel ? rise : fall;
        assign stop_e = esel ? fall : rise;
        assign int_tick = (i == 0) ? tick0 : tick1;
        assign pulse_on = run & (mode == tec_pkg::MODE_PULSE);
        assign mask = (i == 0) ? tec_pkg::CTL0_MASK : tec_pkg::CTL1_MASK;

        // mode 00 matches no term, so it never advances
        // a read of the count gates off its clock for that cycle
        assign adv[i] = run & ~rd_val[i] & (
            ((mode == tec_pkg::MODE_EVENT) & ev_edge) |
            ((mode == tec_pkg::MODE_TIMER) & int_tick) |
            ((mode == tec_pkg::MODE_PULSE) & (pw_q[i] == tec_pkg::PW_MEAS) & int_tick));
        assign ovf[i] = adv[i] & (cnt_q[i] == tec_pkg::CNT_MAX);
        assign pw_done[i] = pulse_on & (pw_q[i] == tec_pkg::PW_MEAS) & stop_e;

        // once done the run bit is gone, so recurring edges find the idle state
        always_comb begin
            pw_d = pw_q[i];
            unique case (pw_q[i])
                tec_pkg::PW_IDLE: begin
                    if (pulse_on) begin
                        pw_d = tec_pkg::PW_ARMED;
                    end
                end
                tec_pkg::PW_ARMED: begin
                    if (!pulse_on) begin
                        pw_d = tec_pkg::PW_IDLE;
                    end else if (start_e) begin
                        pw_d = tec_pkg::PW_MEAS;
                    end
                end
                tec_pkg::PW_MEAS: begin
                    if (!pulse_on || stop_e) begin
                        pw_d = tec_pkg::PW_IDLE;
                    end
                end
                default: begin
                    pw_d = tec_pkg::PW_IDLE;
                end
            endcase
        end

        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                pw_q[i] <= tec_pkg::PW_IDLE;
            end else begin
                pw_q[i] <= pw_d;
            end
        end

        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                cnt_q[i] <= tec_pkg::ZERO8;
            end else if (wr_val[i] && !run) begin
                cnt_q[i] <= WDATA;
            end else if (ovf[i]) begin
                cnt_q[i] <= pre_q[i];
            end else if (adv[i]) begin
                cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end

        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                pre_q[i] <= tec_pkg::ZERO8;
            end else if (wr_val[i]) begin
                pre_q[i] <= WDATA;
            end
        end

        // software write wins over the hardware run clear in the same cycle
        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                ctl_q[i] <= tec_pkg::CTL_RESET;
            end else if (wr_ctl[i]) begin
                ctl_q[i] <= WDATA & mask;
            end else if (pw_done[i]) begin
                ctl_q[i][tec_pkg::RUN_BIT] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // request flags and enables
    // ----------------------------------------
    logic [7:0] irqa_q;
    logic [7:0] irqb_q;
    logic [7:0] irqa_d;
    logic [7:0] irqb_d;

    // overflow in the clearing cycle still sets the flag
    always_comb begin
        irqa_d = wr_irqa ? (WDATA & tec_pkg::IRQA_MASK) : irqa_q;
        irqb_d = wr_irqb ? (WDATA & tec_pkg::IRQB_MASK) : irqb_q;
        if (ovf[0]) begin
            irqa_d[tec_pkg::CNT0_FLAG_BIT] = 1'b1;
        end
        if (ovf[1]) begin
            irqb_d[tec_pkg::CNT1_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            irqa_q <= tec_pkg::ZERO8;
            irqb_q <= tec_pkg::ZERO8;
            CNT0_IRQ <= 1'b0;
            CNT1_IRQ <= 1'b0;
            WAKEUP <= 1'b0;
        end else begin
            irqa_q <= irqa_d;
            irqb_q <= irqb_d;
            CNT0_IRQ <= irqa_d[tec_pkg::CNT0_FLAG_BIT] & irqa_d[tec_pkg::CNT0_EN_BIT];
            CNT1_IRQ <= irqb_d[tec_pkg::CNT1_FLAG_BIT] & irqb_d[tec_pkg::CNT1_EN_BIT];
            WAKEUP <= |ovf;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] rd_mux;

    assign rd_mux =
        (ADDR == tec_pkg::CNT0_VAL_ADDR) ? cnt_q[0] :
        (ADDR == tec_pkg::CNT0_CTL_ADDR) ? ctl_q[0] :
        (ADDR == tec_pkg::CNT1_VAL_ADDR) ? cnt_q[1] :
        (ADDR == tec_pkg::CNT1_CTL_ADDR) ? ctl_q[1] :
        (ADDR == tec_pkg::IRQA_ADDR) ? irqa_q :
        (ADDR == tec_pkg::IRQB_ADDR) ? irqb_q : tec_pkg::ZERO8;

    // data stand only in the cycle after the strobe
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= tec_pkg::ZERO8;
        end else begin
            RDATA <= RD ? rd_mux : tec_pkg::ZERO8;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_ovf_reload;
        ovf[0] |=> cnt_q[0] == $past(pre_q[0]);
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("no reload on overflow");

    property p_flag_set;
        ovf[1] |=> irqb_q[tec_pkg::CNT1_FLAG_BIT] && WAKEUP;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag or wake missing");

    property p_read_count;
        rd_val[0] |=> RDATA == $past(cnt_q[0]) ##1 RDATA == tec_pkg::ZERO8 || $past(RD);
    endproperty
    a_read_count: assert property (p_read_count) else $error("read not the count");

    property p_stop_load;
        wr_val[0] && !ctl0[tec_pkg::RUN_BIT] |=> cnt_q[0] == $past(WDATA);
    endproperty
    a_stop_load: assert property (p_stop_load) else $error("stopped load failed");

    property p_run_keep;
        wr_val[1] && ctl1[tec_pkg::RUN_BIT] && !adv[1]
            |=> cnt_q[1] == $past(cnt_q[1]) && pre_q[1] == $past(WDATA);
    endproperty
    a_run_keep: assert property (p_run_keep) else $error("running count disturbed");

    property p_read_block;
        rd_val[0] |-> !adv[0] && !ovf[0];
    endproperty
    a_read_block: assert property (p_read_block) else $error("count during read");

    property p_mode_off;
        ctl1[tec_pkg::MODE_HI:tec_pkg::MODE_LO] == tec_pkg::MODE_OFF |-> !adv[1] && !ovf[1];
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("unused mode counted");

    property p_pw_clear;
        pw_done[0] && !wr_ctl[0] |=> !ctl0[tec_pkg::RUN_BIT] ##1 !adv[0];
    endproperty
    a_pw_clear: assert property (p_pw_clear) else $error("run not cleared");

    property p_irq_gate;
        !irqa_q[tec_pkg::CNT0_EN_BIT] |-> !CNT0_IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked irq raised");

    property p_div4;
        tick1 |=> !tick1 [*3] ##1 tick1;
    endproperty
    a_div4: assert property (p_div4) else $error("div4 spacing wrong");

    c_ovf0: cover property (ovf[0]);
    c_ovf1: cover property (ovf[1] && irqb_q[tec_pkg::CNT1_EN_BIT]);
    c_pw_done: cover property (pw_done[0]);
    c_event: cover property (adv[1] && ctl1[tec_pkg::MODE_HI:tec_pkg::MODE_LO] == tec_pkg::MODE_EVENT);
endmodule
`default_nettype wire
